// [rtl/lfs_frame_strobe.sv]
// Frame strobe generator for four 12-bit source-synchronous output buses
//
// Summary of operation
// (R1) SYSREF edge restarts frame counter and clock divider
// (R2) Strobe high only in a frame's last interval
// (R3) Frame length field; 0x08 gives strobe at 7
// (R4) Periodic SYSREF must span whole frames
// (R5) Strobe leaves with the same timing as data
// (R6) Per-bus dedicated strobe, full 12-bit samples kept
// (R7) Dedicated strobe ignores the sync gate
// (R8) Buses C, D may borrow A, B clock/strobe
// (R9) Pattern 0x2 with sync: strobe replaces bit 0
// (R10) Pattern 0x3 with sync: 0x000, last 0xFFF
// (R11) Sync de-asserted: full samples pass unmodified
// (R12) Sync source: register bit, pin, or timestamp
// (R13) Sync source resets to the single-ended pin
// (R14) Receiver uses strobes for frames and alignment
// (R15) Per-bus strobe enables disable unused strobes
// (R16) Per-bus data clock enables disable unused clocks
// (R17) Strobe internal or mirrored from timestamp/SYSREF
// (R18) Counter counts from zero, wraps at length-1
`timescale 1ns/1ps
module lfs_frame_strobe (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [lfs_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sample_valid_i,
    input wire logic [lfs_pkg::DATA_W-1:0] sample_data_i,
    output logic sample_ready_o,
    input wire logic link_ready_i,
    input wire logic sysref_i,
    input wire logic single_ended_sync_pin_i,
    input wire logic timestamp_input_i,
    output logic [lfs_pkg::DATA_W-1:0] bus_data_o,
    output logic [lfs_pkg::BUS_CNT-1:0] bus_strobe_pair_o,
    output logic [lfs_pkg::BUS_CNT-1:0] bus_data_clock_o,
    output logic link_valid_o
);
    import lfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [7:0] frame_length_ff;
    logic [7:0] ena_ff;
    logic wb_req;
    logic wr_lo;
    logic [1:0] sync_pattern_select;
    logic [1:0] sync_src;
    logic [1:0] stb_src;
    logic spi_sync;
    logic [BUS_CNT-1:0] strobe_output_enable;
    logic [BUS_CNT-1:0] data_clock_output_enable;
    logic [7:0] cnt_ff;
    logic div_ff;
    logic sync_act;

    assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_lo = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_sel_i[0];
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    assign sync_pattern_select = ctrl_ff[CTRL_PAT_LSB +: 2];
    assign sync_src = ctrl_ff[CTRL_SRC_LSB +: 2];
    assign spi_sync = ctrl_ff[CTRL_SPI_SYNC];
    assign stb_src = ctrl_ff[CTRL_STB_LSB +: 2];
    assign strobe_output_enable = ena_ff[ENA_STB_LSB +: BUS_CNT];
    assign data_clock_output_enable = ena_ff[ENA_DCLK_LSB +: BUS_CNT];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= wb_req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= CTRL_RST; // R13
            frame_length_ff <= FRAME_RST; // R3
            ena_ff <= ENA_RST;
        end
        else if (wr_lo)
        begin
            unique case (wb_adr_i)
                REG_CTRL: ctrl_ff <= wb_dat_i[CTRL_W-1:0]; // R12 R17
                REG_FRAME: frame_length_ff <= wb_dat_i[7:0]; // R3
                REG_ENABLE: ena_ff <= wb_dat_i[7:0]; // R15 R16
                default: ;
            endcase
        end
    end

    // Unmapped addresses read zero and swallow writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_ff <= 32'h0000_0000;
        else if (wb_req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                REG_CTRL: rdata_ff <= {25'h0, ctrl_ff};
                REG_FRAME: rdata_ff <= {24'h0, frame_length_ff};
                REG_ENABLE: rdata_ff <= {24'h0, ena_ff};
                REG_STATUS: rdata_ff <= {22'h0, sync_act, div_ff, cnt_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample buffer

    logic buf_valid;
    logic [DATA_W-1:0] buf_data;
    logic xfer;

    lfs_buf #(
        .W(DATA_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(sample_valid_i),
        .in_ready_o(sample_ready_o),
        .in_data_i(sample_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(link_ready_i),
        .out_data_o(buf_data)
    );

    // One unit interval leaves per accepted word
    assign xfer = buf_valid && link_ready_i;

    ////////////////////////////////////////////////////////////////////////
    // Frame counter and divider

    logic sysref_prev_ff;
    logic sysref_edge;
    logic [7:0] len_m1;
    logic [7:0] cur_idx;
    logic cur_div;
    logic last_ui;
    logic strobe;

    assign sysref_edge = sysref_i && !sysref_prev_ff;
    // A zero length behaves as a one-interval frame
    assign len_m1 = frame_length_ff - 8'(frame_length_ff != 8'h00);
    assign cur_idx = sysref_edge ? 8'h00 : cnt_ff; // R1
    assign cur_div = sysref_edge ? 1'b0 : div_ff; // R1
    assign last_ui = (cur_idx == len_m1); // R2 R3

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sysref_prev_ff <= 1'b0;
        else
            sysref_prev_ff <= sysref_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_ff <= 8'h00;
            div_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= (xfer && last_ui) ? 8'h00 : cur_idx + 8'(xfer); // R1 R18
            div_ff <= cur_div ^ xfer; // R1
        end
    end

    always_comb
    begin
        unique case (stb_src)
            STB_TSTAMP: strobe = timestamp_input_i; // R17
            STB_SYSREF: strobe = sysref_i; // R17
            default: strobe = last_ui; // R2
        endcase
    end

    always_comb
    begin
        unique case (sync_src)
            SRC_SPI: sync_act = spi_sync; // R12
            SRC_TSTAMP: sync_act = timestamp_input_i; // R12
            default: sync_act = single_ended_sync_pin_i; // R12
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-bus output stage

    logic [SAMPLE_W-1:0] word_ff [BUS_CNT];
    logic stb_ff [BUS_CNT];
    logic dclk_ff [BUS_CNT];
    logic valid_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            valid_ff <= 1'b0;
        else
            valid_ff <= xfer;
    end

    assign link_valid_o = valid_ff;

    for (genvar b = 0; b < BUS_CNT; b++)
    begin : g_bus
        logic [SAMPLE_W-1:0] smp;
        logic [SAMPLE_W-1:0] nxt_word;

        assign smp = buf_data[b*SAMPLE_W +: SAMPLE_W];

        always_comb
        begin
            nxt_word = smp; // R6 R11
            if (sync_act && sync_pattern_select == PAT_LSB)
                nxt_word = {smp[SAMPLE_W-1:1], strobe}; // R9
            else if (sync_act && sync_pattern_select == PAT_ALL)
                nxt_word = strobe ? WORD_ONES : WORD_ZERO; // R10
        end

        // Data, strobe and clock share one register stage
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                word_ff[b] <= WORD_ZERO;
                stb_ff[b] <= 1'b0;
                dclk_ff[b] <= 1'b0;
            end
            else
            begin
                if (xfer)
                    word_ff[b] <= nxt_word; // R5
                stb_ff[b] <= (xfer ? strobe : stb_ff[b])
                             && strobe_output_enable[b]; // R7 R15
                // C and D may be shut off and captured on A and B
                dclk_ff[b] <= (xfer ? !cur_div : cur_div)
                              && data_clock_output_enable[b]; // R8 R16
            end
        end

        assign bus_data_o[b*SAMPLE_W +: SAMPLE_W] = word_ff[b];
        assign bus_strobe_pair_o[b] = stb_ff[b];
        assign bus_data_clock_o[b] = dclk_ff[b];
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_strobe_last_ui: assert property ( // R2
        xfer && stb_src == STB_INTERNAL && last_ui
        |=> bus_strobe_pair_o[0] == $past(strobe_output_enable[0]))
        else $error("strobe missing in last interval");

    a_strobe_mid_low: assert property ( // R3
        xfer && stb_src == STB_INTERNAL && !last_ui
        |=> !bus_strobe_pair_o[0])
        else $error("strobe high before last interval");

    a_sysref_restart: assert property ( // R1
        sysref_edge && !xfer |=> cnt_ff == 8'h00 && !div_ff)
        else $error("sysref did not restart frame");

    a_frame_wrap: assert property ( // R18
        xfer && !sysref_edge && cnt_ff == len_m1 |=> cnt_ff == 8'h00)
        else $error("frame counter did not wrap");

    a_count_step: assert property ( // R18
        xfer && !sysref_edge && cnt_ff != len_m1
        |=> cnt_ff == $past(cnt_ff) + 8'h01)
        else $error("frame counter did not advance");

    a_lsb_replace: assert property ( // R9
        xfer && sync_act && sync_pattern_select == PAT_LSB |=>
        bus_data_o[SAMPLE_W-1:0] == {$past(buf_data[SAMPLE_W-1:1]), $past(strobe)})
        else $error("lsb replacement wrong");

    a_all_pairs_low: assert property ( // R10
        xfer && sync_act && sync_pattern_select == PAT_ALL
        && stb_src == STB_INTERNAL && !last_ui
        |=> bus_data_o[SAMPLE_W-1:0] == WORD_ZERO)
        else $error("all-pairs pattern not zero");

    a_pass_thru: assert property ( // R11
        xfer && !sync_act |=> bus_data_o == $past(buf_data))
        else $error("sample altered with sync off");

    a_sync_default: assert property ( // R13
        $past(rst_i) |-> sync_src == SRC_PIN)
        else $error("sync source not pin after reset");

    a_strobe_disabled: assert property ( // R15
        !strobe_output_enable[2] |=> !bus_strobe_pair_o[2])
        else $error("disabled strobe toggled");

    a_dclk_disabled: assert property ( // R16
        !data_clock_output_enable[3] |=> !bus_data_clock_o[3])
        else $error("disabled data clock toggled");

    a_hold_no_xfer: assert property ( // R5
        !xfer |=> !link_valid_o && $stable(bus_data_o))
        else $error("output moved without a word");

    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    c_sysref_mid_frame: cover property (
        sysref_edge && xfer && cnt_ff != 8'h00);
    c_lsb_mode: cover property (
        xfer && sync_act && sync_pattern_select == PAT_LSB && last_ui);
    c_frame_wrap: cover property (
        xfer && last_ui ##1 xfer);
    c_buffer_full: cover property (
        !sample_ready_o && sample_valid_i);
endmodule // lfs_frame_strobe

// [rtl/lfs_pkg.sv]
// Constants shared by the frame strobe generator and its buffer
package lfs_pkg;
    localparam int BUS_CNT = 4;
    localparam int SAMPLE_W = 12;
    localparam int DATA_W = BUS_CNT * SAMPLE_W;
    localparam int ADR_W = 4;
    localparam int BUF_DEPTH = 2;

    // Register byte offsets
    localparam logic [ADR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADR_W-1:0] REG_FRAME = 4'h4;
    localparam logic [ADR_W-1:0] REG_ENABLE = 4'h8;
    localparam logic [ADR_W-1:0] REG_STATUS = 4'hc;

    // Control register fields
    localparam int CTRL_PAT_LSB = 0;
    localparam int CTRL_SRC_LSB = 2;
    localparam int CTRL_SPI_SYNC = 4;
    localparam int CTRL_STB_LSB = 5;
    localparam int CTRL_W = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h04;

    // Enable register fields
    localparam int ENA_STB_LSB = 0;
    localparam int ENA_DCLK_LSB = 4;
    localparam logic [7:0] ENA_RST = 8'hff;

    // Status register fields
    localparam int STAT_DIV = 8;
    localparam int STAT_SYNC = 9;

    localparam logic [7:0] FRAME_RST = 8'h08;

    // Sync pattern select codes
    localparam logic [1:0] PAT_NORMAL = 2'h0;
    localparam logic [1:0] PAT_LSB = 2'h2;
    localparam logic [1:0] PAT_ALL = 2'h3;

    // Sync source codes
    localparam logic [1:0] SRC_SPI = 2'h0;
    localparam logic [1:0] SRC_PIN = 2'h1;
    localparam logic [1:0] SRC_TSTAMP = 2'h2;

    // Strobe source codes
    localparam logic [1:0] STB_INTERNAL = 2'h0;
    localparam logic [1:0] STB_TSTAMP = 2'h1;
    localparam logic [1:0] STB_SYSREF = 2'h2;

    localparam logic [SAMPLE_W-1:0] WORD_ZERO = 12'h000;
    localparam logic [SAMPLE_W-1:0] WORD_ONES = 12'hfff;
endpackage

// [rtl/lfs_buf.sv]
// Two-entry sample buffer with valid and ready on both sides
`timescale 1ns/1ps
module lfs_buf #(
    parameter int W = 48,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic [AW:0] nxt_count;
    logic ready_ff;
    logic push;
    logic pop;

    assign push = in_valid_i && ready_ff;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = ready_ff;
    assign out_valid_o = (count_ff != '0);
    assign out_data_o = mem_ff[rd_ptr_ff];

    always_comb
    begin
        nxt_count = count_ff;
        if (push && !pop)
            nxt_count = count_ff + 1'b1;
        else if (pop && !push)
            nxt_count = count_ff - 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_ff <= '0;
            ready_ff <= 1'b1;
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            count_ff <= nxt_count;
            // Registered full flag keeps the filling side free of paths
            ready_ff <= (nxt_count != FULL);
            if (push)
                wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_data_i;
    end
endmodule // lfs_buf

// [dv/lfs_rx_model.sv]
// Receiver model: paced ready, counts frames from the bus A strobe
`timescale 1ns/1ps
module lfs_rx_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hold_i,
    input wire logic link_valid_i,
    input wire logic [3:0] bus_strobe_pair_i,
    output logic link_ready_o,
    output logic [7:0] frame_cnt_o
);
    logic [1:0] pace_ff;
    logic [7:0] frame_ff;
    ////////////////////////////////////////////////////////////////////////
    // Ready drops one cycle in three so the buffer always sees stalls
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pace_ff <= 2'h0;
        else
            pace_ff <= (pace_ff == 2'h2) ? 2'h0 : pace_ff + 2'h1;
    end
    assign link_ready_o = !hold_i && (pace_ff != 2'h2);
    // Frame boundaries found from strobe A, which also serves bus C
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            frame_ff <= 8'h00;
        else if (link_valid_i && bus_strobe_pair_i[0])
            frame_ff <= frame_ff + 8'h01;
    end
    assign frame_cnt_o = frame_ff;
endmodule // lfs_rx_model

// [dv/lfs_frame_strobe_tb.sv]
// Self-checking bench for the frame strobe generator
`timescale 1ns/1ps
module lfs_frame_strobe_tb;
    import lfs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, dat_o, r;
    logic s_valid = 1'b0, s_ready, l_ready, l_valid;
    logic sysref = 1'b0, pin = 1'b0, ts = 1'b0, hold = 1'b0;
    logic [DATA_W-1:0] s_data = '0, bus_data;
    logic [BUS_CNT-1:0] strobe, dclk;
    logic [7:0] frames, f0;
    logic [DATA_W-1:0] exq[$];
    logic [CTRL_W-1:0] ctrl = CTRL_RST;
    logic [7:0] ena = ENA_RST, frm = FRAME_RST;
    logic div = 1'b0;
    int ui = 0, k = 0, n_mismatch = 0, cmp_count = 0;

    initial forever #2.5 clk_i = ~clk_i;

    lfs_frame_strobe i_lfs_frame_strobe (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .sample_valid_i(s_valid), .sample_data_i(s_data),
        .sample_ready_o(s_ready), .link_ready_i(l_ready),
        .sysref_i(sysref), .single_ended_sync_pin_i(pin),
        .timestamp_input_i(ts), .bus_data_o(bus_data),
        .bus_strobe_pair_o(strobe), .bus_data_clock_o(dclk),
        .link_valid_o(l_valid));
    lfs_rx_model i_lfs_rx_model (.clk_i(clk_i), .rst_i(rst_i),
        .hold_i(hold), .link_valid_i(l_valid), .bus_strobe_pair_i(strobe),
        .link_ready_o(l_ready), .frame_cnt_o(frames));
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("counts: %0d compares, %0d mismatches", cmp_count,
            n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic tmo();
        n_mismatch++;
        $display("mismatch at %0t: wait ran out", $time);
        stop_test();
    endtask
    function automatic logic gate();
        case (ctrl[3:2])
            SRC_SPI: return ctrl[CTRL_SPI_SYNC];
            SRC_TSTAMP: return ts;
            default: return pin;
        endcase
    endfunction
    function automatic logic [DATA_W-1:0] mk(input int v);
        return {12'(v * 5 + 1), 12'(v * 3 + 2), 12'(v * 7), 12'(v + 9)};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Expected word rebuilt from the shadow settings for every UI sent
    task automatic mon();
        logic [DATA_W-1:0] e;
        logic st;
        int n;
        n = (frm == 8'h00) ? 1 : int'(frm);
        st = (ui == n - 1);
        if (ctrl[6:5] == STB_TSTAMP)
            st = ts;
        else if (ctrl[6:5] == STB_SYSREF)
            st = sysref;
        if (exq.size() == 0)
            tmo();
        e = exq.pop_front();
        for (int b = 0; b < BUS_CNT; b++)
            if (gate() && ctrl[1:0] == PAT_LSB)
                e[12 * b] = st;
            else if (gate() && ctrl[1:0] == PAT_ALL)
                e[12 * b +: 12] = st ? WORD_ONES : WORD_ZERO;
        div = ~div;
        chk(bus_data, e, "word");
        chk(strobe, {4{st}} & ena[3:0], "strobe");
        chk(dclk, {4{div}} & ena[7:4], "data clock");
        ui = (ui + 1) % n;
    endtask
    always @(posedge clk_i)
    begin
        if (!rst_i && l_valid === 1'b1)
            mon();
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wb(input logic w, input logic [ADR_W-1:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 50);
        if (i >= 50)
            tmo();
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
        if (a == REG_CTRL)
            ctrl = d[CTRL_W-1:0];
        if (a == REG_FRAME)
            frm = d[7:0];
        if (a == REG_ENABLE)
            ena = d[7:0];
    endtask
    task automatic send(input int n);
        int i;
        for (int j = 0; j < n; j++)
        begin
            s_valid <= 1'b1;
            s_data <= mk(k);
            i = 0;
            do
            begin
                @(posedge clk_i);
                i++;
            end while (s_ready !== 1'b1 && i < 200);
            if (i >= 200)
                tmo();
            exq.push_back(mk(k));
            k++;
        end
        s_valid <= 1'b0;
        i = 0;
        while (exq.size() != 0 && i < 500)
        begin
            @(posedge clk_i);
            i++;
        end
        if (i >= 500)
            tmo();
        repeat (3) @(posedge clk_i);
    endtask
    // Pulsed only while idle, at frame ends or as a deliberate restart
    task automatic pulse();
        @(posedge clk_i);
        sysref <= 1'b1;
        @(posedge clk_i);
        sysref <= 1'b0;
        ui = 0;
        div = 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        wb(1'b0, REG_CTRL, 32'h0, 4'hf);
        chk(r, 32'(CTRL_RST), "ctrl reset");
        wb(1'b0, REG_FRAME, 32'h0, 4'hf);
        chk(r, 32'(FRAME_RST), "frame reset");
        wb(1'b0, REG_ENABLE, 32'h0, 4'hf);
        chk(r, 32'(ENA_RST), "enable reset");
        wb(1'b1, REG_CTRL, 32'h7f, 4'he);
        wb(1'b1, 4'h2, 32'hff, 4'hf);
        wb(1'b0, 4'h2, 32'h0, 4'hf);
        chk(r, 32'h0, "unmapped");
        wb(1'b0, REG_CTRL, 32'h0, 4'hf);
        chk(r, 32'(CTRL_RST), "sel ignored");
        $display("test regs done");
    endtask
    task automatic t_frame();
        logic [7:0] lens[3] = '{8'h08, 8'h03, 8'h00};
        foreach (lens[i])
        begin
            wr(REG_FRAME, 32'(lens[i]));
            pulse();
            f0 = frames;
            send(lens[i] == 8'h00 ? 2 : 2 * int'(lens[i]));
            chk(8'(frames - f0), 8'h02, "frame count");
        end
        wr(REG_FRAME, 32'h8);
        send(3);
        pulse();
        wb(1'b0, REG_STATUS, 32'h0, 4'hf);
        chk(r[7:0], 8'h00, "counter restart");
        chk(r[STAT_DIV], 1'b0, "divider restart");
        send(8);
        $display("test frame done");
    endtask
    task automatic t_modes();
        for (int p = 0; p < 4; p++)
            for (int s = 0; s < 4; s++)
                for (int g = 0; g < 2; g++)
                begin
                    pin <= g[0];
                    ts <= ~g[0];
                    wr(REG_CTRL, {27'h0, ~g[0], 2'(s), 2'(p)});
                    pulse();
                    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
                    chk(r[STAT_SYNC], gate(), "sync gate");
                    send(8);
                end
        $display("test modes done");
    endtask
    task automatic t_enable();
        wr(REG_ENABLE, 32'h32);
        wr(REG_CTRL, {25'h0, STB_TSTAMP, 5'h04});
        ts <= 1'b1;
        send(4);
        wr(REG_CTRL, {25'h0, STB_SYSREF, 5'h04});
        sysref <= 1'b1;
        ui = 0;
        div = 1'b0;
        send(2);
        sysref <= 1'b0;
        wr(REG_CTRL, 32'h07);
        pin <= 1'b1;
        pulse();
        send(8);
        wr(REG_ENABLE, 32'hff);
        $display("test enable done");
    endtask
    task automatic t_stall();
        hold <= 1'b1;
        fork
            send(6);
            begin
                repeat (12) @(posedge clk_i);
                chk(s_ready, 1'b0, "buffer full");
                hold <= 1'b0;
            end
        join
        $display("test stall done");
    endtask

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_frame();
        t_modes();
        t_enable();
        t_stall();
        stop_test();
    end
endmodule // lfs_frame_strobe_tb
